// ===== src/tcmp_defs.vh
// Overview of operation
// - Fetch and data paths run independently, concurrently.
// - Local access completes in one cycle.
// - Each instance allows instructions, data, or both.
// - Instance B is two banks, one port each.
// - Different banks serve requests without arbitration.
// - Bank contention order: data, fetch, slave.
// - Each base is size-aligned in 32-bit space.
// - Enabled region captures every access inside it.
// - Local hits make no external bus transaction.
// - Only privileged writes change region registers.
// - Region write sets base and enable together.
// - Enable change is no synchronisation barrier.
// - Instance may come out of reset enabled.
// - Instance size is a fixed build parameter.
// - Literal load is second access, same interface.
// - Slave port reads and writes both instances.
// - Held fetch-hold after reset blocks all fetches.
// - Fetch starts from local memory after release.
// - Reset places instance A at address zero.
`ifndef TCMP_DEFS_VH
`define TCMP_DEFS_VH
`define TCMP_OFF_REGION_A 12'h000
`define TCMP_OFF_REGION_B 12'h004
`define TCMP_OFF_STATUS   12'h008
`define TCMP_OFF_STALLS   12'h00c
`define TCMP_EN_BIT       0
`define TCMP_INSTR_BIT    1
`define TCMP_DATA_BIT     2
`define TCMP_MODE_RESET   2'h3
`define TCMP_A_RESET_BASE 32'h00000000
`define TCMP_B_RESET_BASE 32'h00100000
`define TCMP_SLV_SEL_BIT  24
`define TCMP_ST_FETCH_BIT 0
`define TCMP_ST_HOLD_BIT  1
`define TCMP_ST_OVLP_BIT  2
`endif

// ===== src/tcmp_ram.v
`timescale 1ns/10ps
`default_nettype none
module tcmp_ram #(
  parameter AW = 12
) (
  input  wire          ref_clk,
  input  wire          en,
  input  wire          we,
  input  wire [3:0]    be,
  input  wire [AW-1:0] idx,
  input  wire [31:0]   wdata,
  output wire [31:0]   rdata
);
  reg [31:0] mem [0:(1<<AW)-1];
  integer    i;

  // Byte-lane write, same cycle as grant
  always @(posedge ref_clk) begin
    if (en && we) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          mem[idx][8*i +: 8] <= wdata[8*i +: 8];
        end
      end
    end
  end

  // Read path, captured by the caller
  assign rdata = mem[idx];
endmodule
`default_nettype wire

// ===== src/tcmp_arb.v
`timescale 1ns/10ps
`default_nettype none
module tcmp_arb (
  input  wire d_req,
  input  wire i_req,
  input  wire s_req,
  output wire d_gnt,
  output wire i_gnt,
  output wire s_gnt,
  output wire stall
);
  // Fixed priority per bank
  assign d_gnt = d_req;
  assign i_gnt = i_req & ~d_req;
  assign s_gnt = s_req & ~d_req & ~i_req;
  // Some request lost and must wait
  assign stall = (d_req & i_req) | (s_req & (d_req | i_req));
endmodule
`default_nettype wire

// ===== src/tcmp_top.v
`timescale 1ns/10ps
`default_nettype none
`include "tcmp_defs.vh"
module tcmp_top #(
  parameter        A_AW         = 12,
  parameter        B_AW         = 11,
  parameter [31:0] A_RESET_BASE = `TCMP_A_RESET_BASE,
  parameter [31:0] B_RESET_BASE = `TCMP_B_RESET_BASE,
  parameter [0:0]  A_RESET_EN   = 1'b1,
  parameter [0:0]  B_RESET_EN   = 1'b0
) (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [2:0]  pprot,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        fetch_hold_n,
  output reg         fetch_enabled,
  input  wire        if_req,
  input  wire [31:0] if_addr,
  output wire        if_gnt,
  output reg         if_rvalid,
  output reg         if_err,
  output reg  [31:0] if_rdata,
  input  wire        d_req,
  input  wire        d_we,
  input  wire [3:0]  d_be,
  input  wire        d_lit,
  input  wire [31:0] d_addr,
  input  wire [31:0] d_wdata,
  output wire        d_gnt,
  output reg         d_rvalid,
  output reg         d_err,
  output reg  [31:0] d_rdata,
  input  wire        s_req,
  input  wire        s_we,
  input  wire [3:0]  s_be,
  input  wire [31:0] s_addr,
  input  wire [31:0] s_wdata,
  output wire        s_gnt,
  output reg         s_rvalid,
  output reg  [31:0] s_rdata,
  input  wire        ext_i_ready,
  output reg         ext_i_req,
  output reg  [31:0] ext_i_addr,
  input  wire        ext_d_ready,
  output reg         ext_d_req,
  output reg         ext_d_we,
  output reg  [3:0]  ext_d_be,
  output reg  [31:0] ext_d_addr,
  output reg  [31:0] ext_d_wdata
);
  // Sizes are fixed at build time
  localparam [31:0] A_MASK = ~((32'h1 << (A_AW + 2)) - 32'h1);
  localparam [31:0] B_MASK = ~((32'h1 << (B_AW + 3)) - 32'h1);
  localparam [31:0] A_RST  = (A_RESET_BASE & A_MASK) |
                             {29'h0, `TCMP_MODE_RESET, A_RESET_EN};
  localparam [31:0] B_RST  = (B_RESET_BASE & B_MASK) |
                             {29'h0, `TCMP_MODE_RESET, B_RESET_EN};
  // Address inside an enabled region
  function tcmp_hit(input [31:0] addr, input [31:0] region,
                    input [31:0] mask);
    begin
      tcmp_hit = region[`TCMP_EN_BIT] && ((addr & mask) == (region & mask));
    end
  endfunction
  // Pick the winning source's value
  function [31:0] tcmp_pick(input gd, input gi, input [31:0] vd,
                            input [31:0] vi, input [31:0] vs);
    begin
      tcmp_pick = gd ? vd : (gi ? vi : vs);
    end
  endfunction
  reg  [31:0] region_a;
  reg  [31:0] region_b;
  reg  [31:0] stall_cnt;
  reg         hold_s1;
  reg         hold_s2;
  reg         hold_s3;
  reg         hold_lvl;
  reg  [31:0] rd_mux;
  reg         rd_bad;
  wire        d_hit_a;
  wire        d_hit_b;
  wire        i_hit_a;
  wire        i_hit_b;
  wire        d_ok_a;
  wire        d_ok_b;
  wire        d_bad;
  wire        i_bad;
  wire        d_miss;
  wire        i_miss;
  wire        dq_a;
  wire        dq_b0;
  wire        dq_b1;
  wire        iq_a;
  wire        iq_b0;
  wire        iq_b1;
  wire        sq_a;
  wire        sq_b0;
  wire        sq_b1;
  wire        ga_d;
  wire        ga_i;
  wire        ga_s;
  wire        g0_d;
  wire        g0_i;
  wire        g0_s;
  wire        g1_d;
  wire        g1_i;
  wire        g1_s;
  wire        st_a;
  wire        st_b0;
  wire        st_b1;
  wire        overlap;
  wire        apb_setup;
  wire        apb_wr;
  wire [31:0] a_addr;
  wire [31:0] b0_addr;
  wire [31:0] b1_addr;
  wire [31:0] rdata_a;
  wire [31:0] rdata_b0;
  wire [31:0] rdata_b1;
  // Region decode for both core paths
  assign d_hit_a = tcmp_hit(d_addr, region_a, A_MASK);
  assign d_hit_b = tcmp_hit(d_addr, region_b, B_MASK);
  assign i_hit_a = tcmp_hit(if_addr, region_a, A_MASK);
  assign i_hit_b = tcmp_hit(if_addr, region_b, B_MASK);
  // Literal reads ride the data path into code regions
  assign d_ok_a = region_a[`TCMP_DATA_BIT] |
                  (d_lit & ~d_we & region_a[`TCMP_INSTR_BIT]);
  assign d_ok_b = region_b[`TCMP_DATA_BIT] |
                  (d_lit & ~d_we & region_b[`TCMP_INSTR_BIT]);
  assign d_bad  = d_req & ((d_hit_a & ~d_ok_a) | (d_hit_b & ~d_ok_b));
  assign i_bad  = if_req & fetch_enabled &
                  ((i_hit_a & ~region_a[`TCMP_INSTR_BIT]) |
                   (i_hit_b & ~region_b[`TCMP_INSTR_BIT]));
  assign d_miss = d_req & ~d_hit_a & ~d_hit_b;
  assign i_miss = if_req & fetch_enabled & ~i_hit_a & ~i_hit_b;
  // Per-bank requests; B interleaves words on bit 2
  assign dq_a  = d_req & d_hit_a & d_ok_a;
  assign dq_b0 = d_req & d_hit_b & d_ok_b & ~d_addr[2];
  assign dq_b1 = d_req & d_hit_b & d_ok_b & d_addr[2];
  assign iq_a  = if_req & fetch_enabled & i_hit_a &
                 region_a[`TCMP_INSTR_BIT];
  assign iq_b0 = if_req & fetch_enabled & i_hit_b &
                 region_b[`TCMP_INSTR_BIT] & ~if_addr[2];
  assign iq_b1 = if_req & fetch_enabled & i_hit_b &
                 region_b[`TCMP_INSTR_BIT] & if_addr[2];
  assign sq_a  = s_req & ~s_addr[`TCMP_SLV_SEL_BIT];
  assign sq_b0 = s_req & s_addr[`TCMP_SLV_SEL_BIT] & ~s_addr[2];
  assign sq_b1 = s_req & s_addr[`TCMP_SLV_SEL_BIT] & s_addr[2];
  // One arbiter per bank, so separate banks never wait
  tcmp_arb u_arb_a (
    .d_req (dq_a),
    .i_req (iq_a),
    .s_req (sq_a),
    .d_gnt (ga_d),
    .i_gnt (ga_i),
    .s_gnt (ga_s),
    .stall (st_a)
  );
  tcmp_arb u_arb_b0 (
    .d_req (dq_b0),
    .i_req (iq_b0),
    .s_req (sq_b0),
    .d_gnt (g0_d),
    .i_gnt (g0_i),
    .s_gnt (g0_s),
    .stall (st_b0)
  );
  tcmp_arb u_arb_b1 (
    .d_req (dq_b1),
    .i_req (iq_b1),
    .s_req (sq_b1),
    .d_gnt (g1_d),
    .i_gnt (g1_i),
    .s_gnt (g1_s),
    .stall (st_b1)
  );

  // Bank addresses from the winners
  assign a_addr  = tcmp_pick(ga_d, ga_i, d_addr, if_addr, s_addr);
  assign b0_addr = tcmp_pick(g0_d, g0_i, d_addr, if_addr, s_addr);
  assign b1_addr = tcmp_pick(g1_d, g1_i, d_addr, if_addr, s_addr);
  tcmp_ram #(.AW(A_AW)) u_ram_a (
    .ref_clk (ref_clk),
    .en      (ga_d | ga_i | ga_s),
    .we      ((ga_d & d_we) | (ga_s & s_we)),
    .be      (ga_d ? d_be : s_be),
    .idx     (a_addr[A_AW+1:2]),
    .wdata   (ga_d ? d_wdata : s_wdata),
    .rdata   (rdata_a)
  );
  tcmp_ram #(.AW(B_AW)) u_ram_b0 (
    .ref_clk (ref_clk),
    .en      (g0_d | g0_i | g0_s),
    .we      ((g0_d & d_we) | (g0_s & s_we)),
    .be      (g0_d ? d_be : s_be),
    .idx     (b0_addr[B_AW+2:3]),
    .wdata   (g0_d ? d_wdata : s_wdata),
    .rdata   (rdata_b0)
  );
  tcmp_ram #(.AW(B_AW)) u_ram_b1 (
    .ref_clk (ref_clk),
    .en      (g1_d | g1_i | g1_s),
    .we      ((g1_d & d_we) | (g1_s & s_we)),
    .be      (g1_d ? d_be : s_be),
    .idx     (b1_addr[B_AW+2:3]),
    .wdata   (g1_d ? d_wdata : s_wdata),
    .rdata   (rdata_b1)
  );
  // Accept strobes; losers see no grant and hold
  assign d_gnt  = d_bad | (d_miss & ext_d_ready) |
                  ga_d | g0_d | g1_d;
  assign if_gnt = i_bad | (i_miss & ext_i_ready) |
                  ga_i | g0_i | g1_i;
  assign s_gnt  = ga_s | g0_s | g1_s;
  // Core and slave answers, one cycle after grant
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      d_rvalid  <= 1'b0;
      d_err     <= 1'b0;
      d_rdata   <= 32'h0;
      if_rvalid <= 1'b0;
      if_err    <= 1'b0;
      if_rdata  <= 32'h0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
    end else begin
      d_rvalid  <= (ga_d | g0_d | g1_d) & ~d_we;
      d_err     <= d_bad;
      d_rdata   <= ga_d ? rdata_a : (g0_d ? rdata_b0 : rdata_b1);
      if_rvalid <= ga_i | g0_i | g1_i;
      if_err    <= i_bad;
      if_rdata  <= ga_i ? rdata_a : (g0_i ? rdata_b0 : rdata_b1);
      s_rvalid  <= (ga_s | g0_s | g1_s) & ~s_we;
      s_rdata   <= ga_s ? rdata_a : (g0_s ? rdata_b0 : rdata_b1);
    end
  end

  // Forward misses only; local hits stay off the bus
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      ext_i_req   <= 1'b0;
      ext_i_addr  <= 32'h0;
      ext_d_req   <= 1'b0;
      ext_d_we    <= 1'b0;
      ext_d_be    <= 4'h0;
      ext_d_addr  <= 32'h0;
      ext_d_wdata <= 32'h0;
    end else begin
      ext_i_req <= i_miss & ext_i_ready;
      ext_d_req <= d_miss & ext_d_ready;
      if (i_miss && ext_i_ready) begin
        ext_i_addr <= if_addr;
      end
      if (d_miss && ext_d_ready) begin
        ext_d_we    <= d_we;
        ext_d_be    <= d_be;
        ext_d_addr  <= d_addr;
        ext_d_wdata <= d_wdata;
      end
    end
  end

  // Fetch-hold pin: three stages, change when last two agree
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      hold_s1  <= 1'b0;
      hold_s2  <= 1'b0;
      hold_s3  <= 1'b0;
      hold_lvl <= 1'b0;
    end else begin
      hold_s1 <= fetch_hold_n;
      hold_s2 <= hold_s1;
      hold_s3 <= hold_s2;
      if (hold_s2 == hold_s3) begin
        hold_lvl <= hold_s3;
      end
    end
  end

  // Fetch stays blocked from reset until the hold is released
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      fetch_enabled <= 1'b0;
    end else if (hold_lvl) begin
      fetch_enabled <= 1'b1;
    end
  end

  // Regions overlapping means software slipped
  assign overlap = region_a[`TCMP_EN_BIT] &
                   (tcmp_hit(region_a, region_b, B_MASK) |
                    tcmp_hit(region_b, region_a, A_MASK));

  // APB phases
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite & ~pslverr;
  // Read data and error for the coming access phase
  always @* begin
    rd_mux = 32'h0;
    rd_bad = 1'b0;
    case (paddr)
      `TCMP_OFF_REGION_A: rd_mux = region_a;
      `TCMP_OFF_REGION_B: rd_mux = region_b;
      `TCMP_OFF_STATUS: begin
        rd_mux[`TCMP_ST_FETCH_BIT] = fetch_enabled;
        rd_mux[`TCMP_ST_HOLD_BIT]  = hold_lvl;
        rd_mux[`TCMP_ST_OVLP_BIT]  = overlap;
        rd_bad = pwrite;
      end
      `TCMP_OFF_STALLS: rd_mux = stall_cnt;
      default: rd_bad = 1'b1;
    endcase
  end

  // One wait-free access phase per transfer
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= rd_bad | (pwrite & ~pprot[0]);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Region registers; new value acts next cycle, no drain
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      region_a <= A_RST;
      region_b <= B_RST;
    end else if (apb_wr) begin
      if (paddr == `TCMP_OFF_REGION_A) begin
        region_a <= (pwdata & A_MASK) | {29'h0, pwdata[2:0]};
      end
      if (paddr == `TCMP_OFF_REGION_B) begin
        region_b <= (pwdata & B_MASK) | {29'h0, pwdata[2:0]};
      end
    end
  end

  // Contention counter; a stall in the clearing cycle counts
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      stall_cnt <= 32'h0;
    end else if (apb_wr && paddr == `TCMP_OFF_STALLS) begin
      stall_cnt <= {31'h0, st_a | st_b0 | st_b1};
    end else if (st_a || st_b0 || st_b1) begin
      stall_cnt <= stall_cnt + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tcmp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tcmp_monitor #(
  parameter A_AW = 12
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        fetch_hold_n,
  input wire logic        fetch_enabled,
  input wire logic        if_req,
  input wire logic [31:0] if_addr,
  input wire logic        if_gnt,
  input wire logic        if_rvalid,
  input wire logic        d_req,
  input wire logic        d_we,
  input wire logic [31:0] d_addr,
  input wire logic [31:0] d_wdata,
  input wire logic        d_gnt,
  input wire logic        d_rvalid,
  input wire logic        s_req,
  input wire logic        s_we,
  input wire logic [31:0] s_addr,
  input wire logic        s_gnt,
  input wire logic        s_rvalid,
  input wire logic        ext_d_req,
  input wire logic [31:0] ext_d_addr,
  input wire logic [31:0] ext_d_wdata
);
  logic d_in_a;
  logic i_in_a;
  // Hits in instance A at its reset base
  assign d_in_a = (d_addr >> (A_AW + 2)) == 0;
  assign i_in_a = (if_addr >> (A_AW + 2)) == 0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Fetch hold and path timing
  a_fetch_held: assert property (!fetch_enabled |-> !if_gnt) else $error("fetch granted while held");
  a_hold_keeps: assert property (!fetch_hold_n [*4] ##1 !fetch_enabled |=> !fetch_enabled)
    else $error("fetch enabled while hold low");
  a_fetch_local: assert property (if_req && if_gnt && i_in_a |=> if_rvalid) else $error("no local fetch data");
  a_local_lat: assert property (d_req && d_gnt && d_in_a && !d_we |=> d_rvalid) else $error("local read late");
  a_local_no_ext: assert property (d_req && d_gnt && d_in_a |=> !ext_d_req) else $error("local hit went out");
  a_miss_fwd: assert property (d_req && d_gnt && d_addr[31] |=> ext_d_req && ext_d_addr == $past(d_addr)
    && ext_d_wdata == $past(d_wdata)) else $error("miss not forwarded");
  a_slv_read: assert property (s_req && s_gnt && !s_we |=> s_rvalid) else $error("slave read lost");
  // Arbitration between sources, APB answer timing and covers
  a_data_first: assert property (d_req && d_in_a && s_req && !s_addr[24] |-> d_gnt && !s_gnt)
    else $error("data lost to slave");
  a_fetch_over_slv: assert property (if_gnt && i_in_a && s_req && !s_addr[24] |-> !s_gnt)
    else $error("slave beat fetch");
  a_banks_apart: assert property (d_gnt && d_in_a && !if_req && s_req && s_addr[24] |-> s_gnt)
    else $error("other bank stalled");
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("apb answer late");
  c_contend: cover property (d_req && s_req && !s_gnt);
  c_miss: cover property (ext_d_req);
  c_release: cover property ($rose(fetch_enabled));
endmodule
bind tcmp_top tcmp_monitor #(.A_AW(A_AW)) mon (.ref_clk, .reset_n, .psel, .penable, .pready, .fetch_hold_n,
  .fetch_enabled, .if_req, .if_addr, .if_gnt, .if_rvalid, .d_req, .d_we, .d_addr, .d_wdata, .d_gnt, .d_rvalid,
  .s_req, .s_we, .s_addr, .s_gnt, .s_rvalid, .ext_d_req, .ext_d_addr, .ext_d_wdata);
`default_nettype wire

// ===== dv/tcmp_preloader.sv
`timescale 1ns/10ps
`default_nettype none
module tcmp_preloader (
  input wire logic         ref_clk,
  input wire logic         s_gnt,
  input wire logic         s_rvalid,
  input wire logic  [31:0] s_rdata,
  output logic             s_req,
  output logic             s_we,
  output logic      [3:0]  s_be,
  output logic      [31:0] s_addr,
  output logic      [31:0] s_wdata,
  output logic             fetch_hold_n
);
  logic [31:0] got;
  // Idle master, fetch held from the start
  initial begin
    s_req = 1'h0;
    s_we = 1'h0;
    s_be = 4'hf;
    s_addr = '0;
    s_wdata = '0;
    fetch_hold_n = 1'h0;
  end
  // One word, held until granted, then scrambled
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    s_req <= 1'h1;
    s_we <= w;
    s_addr <= a;
    s_wdata <= d;
    do @(posedge ref_clk); while (s_gnt !== 1'h1);
    s_req <= 1'h0;
    s_addr <= ~a;
    s_wdata <= ~d;
    if (!w) begin
      @(posedge ref_clk);
      got = s_rvalid ? s_rdata : '1;
    end
  endtask
  // Preload done, let the core fetch
  task release_hold;
    @(posedge ref_clk);
    fetch_hold_n <= 1'h1;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        if_req = 1'h0, d_req = 1'h0, d_we = 1'h0, d_lit = 1'h0, ext_d_ready = 1'h0, aerr, rv;
  logic [11:0] paddr = '0;
  logic [2:0]  pprot = 3'h1;
  logic [31:0] pwdata = '0, if_addr = '0, d_addr = '0, d_wdata = '0, rd, frd, xa, fxa;
  logic [4:0]  xw;
  wire logic   pready, pslverr, fetch_enabled, if_gnt, if_rvalid, if_err, d_gnt, d_rvalid, d_err;
  wire logic   s_gnt, s_rvalid, ext_i_req, ext_d_req, ext_d_we, s_req, s_we, fetch_hold_n;
  wire logic [31:0] prdata, if_rdata, d_rdata, s_rdata, ext_i_addr, ext_d_addr, ext_d_wdata, s_addr, s_wdata;
  wire logic [3:0]  ext_d_be, s_be;
  int          err_total = 0, check_count = 0, cyc = 0, dt, ft;

  tcmp_top dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .pready, .prdata,
    .pslverr, .fetch_hold_n, .fetch_enabled, .if_req, .if_addr, .if_gnt, .if_rvalid, .if_err, .if_rdata,
    .d_req, .d_we, .d_be(4'hf), .d_lit, .d_addr, .d_wdata, .d_gnt, .d_rvalid, .d_err, .d_rdata,
    .s_req, .s_we, .s_be, .s_addr, .s_wdata, .s_gnt, .s_rvalid, .s_rdata, .ext_i_ready(1'h1), .ext_i_req,
    .ext_i_addr, .ext_d_ready, .ext_d_req, .ext_d_we, .ext_d_be, .ext_d_addr, .ext_d_wdata);
  tcmp_preloader pm (.ref_clk, .s_gnt, .s_rvalid, .s_rdata, .s_req, .s_we, .s_be, .s_addr, .s_wdata,
    .fetch_hold_n);

  // Clock and hang guard
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task give_verdict;
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  // APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [2:0] pr);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pprot <= pr;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    aerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Core data access; answer sampled one cycle after grant
  task dacc(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    d_req <= 1'h1;
    d_we <= w;
    d_addr <= a;
    d_wdata <= wd;
    do @(posedge ref_clk); while (d_gnt !== 1'h1);
    dt = cyc;
    d_req <= 1'h0;
    d_addr <= ~a;
    @(posedge ref_clk);
    rd = d_rdata;
    rv = d_rvalid;
    aerr = d_err;
    xa = ext_d_req ? ext_d_addr : '1;
    xw = ext_d_req ? {ext_d_we, ext_d_be} : '0;
  endtask
  // Core fetch
  task facc(input logic [31:0] a);
    @(posedge ref_clk);
    if_req <= 1'h1;
    if_addr <= a;
    do @(posedge ref_clk); while (if_gnt !== 1'h1);
    ft = cyc;
    if_req <= 1'h0;
    @(posedge ref_clk);
    frd = if_rvalid ? if_rdata : '1;
    aerr = if_err;
    fxa = ext_i_req ? ext_i_addr : '1;
  endtask

  task t_regs;
    apb(1'h0, 12'h000, '0, 3'h1);
    chk("region_a", 32'h00000007, rd);
    apb(1'h0, 12'h004, '0, 3'h1);
    chk("region_b", 32'h00100006, rd);
    apb(1'h1, 12'h000, 32'h00002007, 3'h1);
    apb(1'h0, 12'h000, '0, 3'h1);
    chk("region_a", 32'h00000007, rd);
    apb(1'h1, 12'h004, 32'h00200007, 3'h0);
    chk("pslverr", 32'h1, aerr);
    apb(1'h0, 12'h004, '0, 3'h1);
    chk("region_b", 32'h00100006, rd);
    apb(1'h0, 12'h010, '0, 3'h1);
    chk("pslverr", 32'h1, aerr);
  endtask
  task t_preload;
    pm.xfer(1'h1, 32'h00000000, 32'h1234abcd, 0);
    pm.xfer(1'h1, 32'h01000004, 32'h5a5a0f0f, 2);
    pm.xfer(1'h0, 32'h00000000, '0, 1);
    chk("s_rdata", 32'h1234abcd, pm.got);
    pm.xfer(1'h0, 32'h01000004, '0, 0);
    chk("s_rdata", 32'h5a5a0f0f, pm.got);
    if_req <= 1'h1;
    repeat (8) @(posedge ref_clk);
    chk("if_gnt", 32'h0, if_gnt);
    pm.release_hold();
    facc(32'h00000000);
    chk("if_rdata", 32'h1234abcd, frd);
  endtask
  task t_contend;
    fork
      pm.xfer(1'h0, 32'h00000000, '0, 0);
      dacc(1'h0, 32'h00000000, '0);
      facc(32'h00000000);
    join
    chk("d_rdata", 32'h1234abcd, rd);
    chk("fetch after data", 32'h1, ft > dt);
    chk("s_rdata", 32'h1234abcd, pm.got);
    fork
      pm.xfer(1'h0, 32'h01000004, '0, 0);
      dacc(1'h0, 32'h00000000, '0);
    join
    chk("s_rdata", 32'h5a5a0f0f, pm.got);
    apb(1'h0, 12'h00c, '0, 3'h1);
    chk("stall_cnt", 32'h2, rd);
    apb(1'h0, 12'h008, '0, 3'h1);
    chk("status", 32'h3, rd);
  endtask
  task t_regions;
    fork
      dacc(1'h1, 32'h80000010, 32'hcafe0001);
      repeat (3) @(posedge ref_clk) ext_d_ready <= 1'h1;
    join
    chk("ext_d_addr", 32'h80000010, xa);
    chk("ext_d_we_be", 32'h1f, xw);
    dacc(1'h0, 32'h00100004, '0);
    chk("ext_d_addr", 32'h00100004, xa);
    apb(1'h1, 12'h004, 32'h00100005, 3'h1);
    dacc(1'h0, 32'h00100004, '0);
    chk("d_rdata", 32'h5a5a0f0f, rd);
    chk("ext_d_addr", 32'hffffffff, xa);
    facc(32'h00100004);
    chk("if_err", 32'h1, aerr);
    facc(32'h80000020);
    chk("ext_i_addr", 32'h80000020, fxa);
    apb(1'h1, 12'h004, 32'h00100003, 3'h1);
    dacc(1'h0, 32'h00100004, '0);
    chk("d_err", 32'h1, aerr);
    chk("ext_d_addr", 32'hffffffff, xa);
    d_lit <= 1'h1;
    dacc(1'h0, 32'h00100004, '0);
    chk("d_rdata", 32'h5a5a0f0f, rd);
    chk("d_rvalid", 32'h1, rv);
    d_lit <= 1'h0;
    facc(32'h00100004);
    chk("if_rdata", 32'h5a5a0f0f, frd);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_regs();
    t_preload();
    t_contend();
    t_regions();
    give_verdict();
  end
endmodule
`default_nettype wire
